// ### interval_timer_interrupts_tb.sv
// Self-checking bench for the interval timer block
`timescale 1ns/100ps
module interval_timer_interrupts_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic pulseOutActive = 1'b0;
  logic [15:0] fastCounterSetup = 16'h0000;
  logic subReq;
  logic [15:0] subNum;
  logic [1:0] subTimer;
  logic [2:0][7:0] reqCnt;
  logic [15:0] lastNum;
  logic [31:0] rv;
  int miscompares = 0;
  int checks_done = 0;
  // Bad operand sets: period, subroutine, set value, code
  logic [15:0] badPer [4] = '{16'h0004, 16'h0005, 16'h0005, 16'h0005};
  logic [15:0] badSub [4] = '{16'h0001, 16'h0256, 16'h0001, 16'h0001};
  logic [15:0] badSet [4] = '{16'h0001, 16'h0001, 16'h00A0, 16'h0001};
  logic [15:0] badCode [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0009};
  logic [15:0] okCode [3] = '{16'h0000, 16'h0004, 16'h0005};

  // Free-running 200 MHz clock
  initial forever #2.5 mclk = ~mclk;

  // Short unit of 4 cycles keeps long periods cheap
  itm_interval_timer #(.UNIT_CYCLES(4)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pulseOutActive(pulseOutActive),
    .fastCounterSetup(fastCounterSetup), .subReq(subReq),
    .subNum(subNum), .subTimer(subTimer)
  );

  itm_sub_engine eng_u (
    .mclk(mclk), .sys_rst(sys_rst), .subReq(subReq), .subNum(subNum),
    .subTimer(subTimer), .reqCnt(reqCnt), .lastNum(lastNum)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // Stage operands, issue the command, let results land
  task automatic cmd(input logic [15:0] c, sv, per, sn);
    wr(itm_pkg::OFF_SETVAL, {16'h0, sv});
    wr(itm_pkg::OFF_PERIOD, {16'h0, per});
    wr(itm_pkg::OFF_SUBNUM, {16'h0, sn});
    wr(itm_pkg::OFF_CMD, {16'h0, c});
    @(posedge mclk);
  endtask

  // Bounded wait for a call count; running out ends the run
  task automatic waitCnt(input int t, input logic [7:0] n, input int lim);
    for (int i = 0; i < lim && reqCnt[t] !== n; i++) @(posedge mclk);
    if (reqCnt[t] !== n) begin
      miscompares++;
      $display("CHECK FAILED wait exp %h seen %h", n, reqCnt[t]);
      test_done();
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(itm_pkg::OFF_STATUS, rv);
    chk("status", rv, 32'h0);
    chk("calls", {8'h0, reqCnt}, 32'h0);
    // One-shot timer 1, 3 x 5 units = 60 cycles
    cmd(16'h0001, 16'h0003, 16'h0005, 16'h0023);
    rd(itm_pkg::OFF_STATUS, rv);
    chk("status", rv, 32'h2);
    repeat (45) @(posedge mclk);
    chk("early", {24'h0, reqCnt[1]}, 32'h0);
    waitCnt(1, 8'h01, 30);
    chk("subnum", {16'h0, lastNum}, 32'h23);
    repeat (100) @(posedge mclk);
    chk("once", {24'h0, reqCnt[1]}, 32'h1);
    rd(itm_pkg::OFF_STATUS, rv);
    chk("halted", rv, 32'h0);
    // Scheduled timer 0 with top routine number, period 5 units, a call every 60 cycles
    cmd(16'h0003, 16'h0003, 16'h0005, 16'h0255);
    waitCnt(0, 8'h01, 90);
    waitCnt(0, 8'h02, 70);
    repeat (22) @(posedge mclk);
    wr(itm_pkg::OFF_CMD, 32'h6);
    @(posedge mclk);
    rd(itm_pkg::OFF_RDCOUNT, rv);
    chk("count", rv, 32'h1);
    rd(itm_pkg::OFF_RDPERIOD, rv);
    chk("period", rv, 32'h5);
    rd(itm_pkg::OFF_RDRESID, rv);
    chk("resid", {31'h0, rv < 32'h5}, 32'h1);
    wr(itm_pkg::OFF_CMD, 32'h8000);
    @(posedge mclk);
    rd(itm_pkg::OFF_STATUS, rv);
    chk("stopped", rv, 32'h0);
    repeat (150) @(posedge mclk);
    chk("nocall", {24'h0, reqCnt[0]}, 32'h2);
    // Reading a stopped timer gives zero in every result word
    wr(itm_pkg::OFF_CMD, 32'h7);
    @(posedge mclk);
    for (int k = 0; k < 3; k++) begin
      rd(5'(itm_pkg::OFF_RDCOUNT + 4 * k), rv);
      chk("rdstop", rv, 32'h0);
    end
    // Out-of-range or non-decimal operands are refused
    for (int k = 0; k < 4; k++) begin
      cmd(badCode[k], badSet[k], badPer[k], badSub[k]);
      rd(itm_pkg::OFF_STATUS, rv);
      chk("reject", rv, 32'h8);
    end
    // Pin and setup word change only at a rising edge
    @(posedge mclk);
    pulseOutActive <= 1'b1;
    repeat (4) @(posedge mclk);
    cmd(16'h0000, 16'h0001, 16'h0005, 16'h0001);
    rd(itm_pkg::OFF_STATUS, rv);
    chk("pulsebusy", rv, 32'h8);
    @(posedge mclk);
    pulseOutActive <= 1'b0;
    fastCounterSetup <= 16'h0100;
    cmd(16'h0002, 16'h0001, 16'h0005, 16'h0001);
    rd(itm_pkg::OFF_STATUS, rv);
    chk("fastused", rv, 32'h8);
    @(posedge mclk);
    fastCounterSetup <= itm_pkg::FAST_SETUP_DEFAULT;
    // Immediate set value on timer 2 uses a 10-unit period
    cmd(16'h1002, 16'h0001, 16'h0000, 16'h0007);
    rd(itm_pkg::OFF_STATUS, rv);
    chk("immstart", rv, 32'h4);
    wr(itm_pkg::OFF_CMD, 32'h8);
    @(posedge mclk);
    rd(itm_pkg::OFF_RDPERIOD, rv);
    chk("immper", rv, 32'h10);
    waitCnt(2, 8'h01, 60);
    chk("immsub", {16'h0, lastNum}, 32'h7);
    // Remaining start codes, each stopped again
    for (int k = 0; k < 3; k++) begin
      cmd(okCode[k], 16'h0009, 16'h0320, 16'h0000);
      rd(itm_pkg::OFF_STATUS, rv);
      chk("run", rv, 32'(1 << (okCode[k] % 3)));
      wr(itm_pkg::OFF_CMD, 32'h8000 | 32'(okCode[k] % 16'h0003));
      @(posedge mclk);
      rd(itm_pkg::OFF_STATUS, rv);
      chk("stop", rv, 32'h0);
    end
    test_done();
  end
endmodule

// ### itm_interval_timer.sv
// Three BCD interval timers with subroutine request output
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module itm_interval_timer #(
  parameter int UNIT_CYCLES = itm_pkg::UNIT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic pulseOutActive,
  input wire logic [15:0] fastCounterSetup,
  output logic subReq,
  output logic [15:0] subNum,
  output logic [1:0] subTimer
);
  localparam int NT = itm_pkg::NUM_TIMERS;
  localparam int PRE_W = $clog2(UNIT_CYCLES);

  // All four digits decimal
  function automatic logic bcdOk(input logic [15:0] v);
    return v[15:12] <= 4'h9 && v[11:8] <= 4'h9 &&
           v[7:4] <= 4'h9 && v[3:0] <= 4'h9;
  endfunction

  // Four BCD digits to binary
  function automatic logic [13:0] bcdToBin(input logic [15:0] v);
    return 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 +
           14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
  endfunction

  // Binary to four BCD digits, shift and add three
  function automatic logic [15:0] binToBcd(input logic [13:0] v);
    logic [29:0] s;
    s = 30'h0;
    s[13:0] = v;
    for (int k = 0; k < 14; k++) begin
      for (int d = 0; d < 4; d++) begin
        if (s[14+4*d +: 4] > 4'h4) begin
          s[14+4*d +: 4] = s[14+4*d +: 4] + 4'h3;
        end
      end
      s = {s[28:0], 1'b0};
    end
    return s[29:14];
  endfunction

  // Staged operands, written ahead of a command
  logic [15:0] stageSet;
  logic [15:0] stagePer;
  logic [15:0] stageSub;
  // Pulse output flag crosses from a pin
  logic pulseMeta;
  logic pulseSync;
  // Per-timer state
  logic [NT-1:0] running, sched;
  logic [13:0] pv [NT];
  logic [13:0] setv [NT];
  logic [8:0] period [NT];
  logic [8:0] tenth [NT];
  logic [13:0] decCnt [NT];
  logic [15:0] subn [NT];
  logic [PRE_W-1:0] pre [NT];
  // Unit tick, decrement and expiry strobes
  logic [NT-1:0] tick, decEv, expire;
  // Requests waiting for the execution engine
  logic [NT-1:0] pending, grant;
  logic [1:0] grantIdx;
  // Read results and status
  logic [15:0] rdCnt, rdPer, rdRes;
  logic rejected;

  // Synchroniser for the pulse output level
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseMeta <= 1'b0;
      pulseSync <= 1'b0;
    end else begin
      pulseMeta <= pulseOutActive;
      pulseSync <= pulseMeta;
    end
  end

  // Command decode
  logic cmdWr, fcOk, stopBit, immBit, isStart, isRead, isStop;
  logic opsOk, gateOk, startOk;
  logic [15:0] fcRaw;
  logic [13:0] fcB, setBin, perBin, subBin;
  logic [1:0] tIdx;
  logic [8:0] perUse;
  logic [NT-1:0] startHit, stopHit;

  assign cmdWr = regWr && regAddr == itm_pkg::OFF_CMD;
  assign fcRaw = {4'h0, regWdata[itm_pkg::CMD_CODE_LSB +: 12]};
  assign fcOk = bcdOk(fcRaw);
  assign fcB = bcdToBin(fcRaw);
  assign stopBit = regWdata[itm_pkg::CMD_STOP_BIT];
  assign immBit = regWdata[itm_pkg::CMD_IMM_BIT];
  // Codes 0..5 start, 6..8 read
  assign isStart = fcOk && !stopBit && fcB < itm_pkg::FC_READ_BASE;
  assign isRead = fcOk && !stopBit && fcB >= itm_pkg::FC_READ_BASE &&
                  fcB <= itm_pkg::FC_READ_LAST;
  assign isStop = fcOk && stopBit && fcB < itm_pkg::FC_SCHED_BASE;
  // Timer index from the code
  always_comb begin
    if (fcB < itm_pkg::FC_SCHED_BASE) begin
      tIdx = fcB[1:0];
    end else if (fcB < itm_pkg::FC_READ_BASE) begin
      tIdx = 2'(fcB - itm_pkg::FC_SCHED_BASE);
    end else begin
      tIdx = 2'(fcB - itm_pkg::FC_READ_BASE);
    end
  end
  assign setBin = bcdToBin(stageSet);
  assign perBin = bcdToBin(stagePer);
  assign subBin = bcdToBin(stageSub);
  // Immediate set value fixes the period at 1 ms
  assign perUse = immBit ? itm_pkg::IMM_PERIOD : perBin[8:0];
  // Operand checks; a bad start only sets the reject flag
  assign opsOk = bcdOk(stageSet) && bcdOk(stageSub) &&
                 subBin <= itm_pkg::SUB_MAX &&
                 (immBit || (bcdOk(stagePer) &&
                  perBin >= itm_pkg::PERIOD_MIN &&
                  perBin <= itm_pkg::PERIOD_MAX));
  // Shared resources block timer 0 and timer 2
  assign gateOk = !(tIdx == 2'd0 && pulseSync) &&
                  !(tIdx == 2'd2 &&
                    fastCounterSetup != itm_pkg::FAST_SETUP_DEFAULT);
  assign startOk = cmdWr && isStart && opsOk && gateOk;
  assign startHit = startOk ? NT'(1) << tIdx : '0;
  assign stopHit = (cmdWr && isStop) ? NT'(1) << tIdx : '0;

  // Staging registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stageSet <= itm_pkg::STAGE_RST;
      stagePer <= itm_pkg::STAGE_RST;
      stageSub <= itm_pkg::STAGE_RST;
    end else if (regWr) begin
      if (regAddr == itm_pkg::OFF_SETVAL) begin
        stageSet <= regWdata[15:0];
      end
      if (regAddr == itm_pkg::OFF_PERIOD) begin
        stagePer <= regWdata[15:0];
      end
      if (regAddr == itm_pkg::OFF_SUBNUM) begin
        stageSub <= regWdata[15:0];
      end
    end
  end

  // One timer per index
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    assign tick[i] = running[i] && pre[i] == PRE_W'(UNIT_CYCLES - 1);
    assign decEv[i] = tick[i] && tenth[i] == period[i] - 9'h001;
    // Set value 0 expires at the first period end
    assign expire[i] = decEv[i] && pv[i] <= 14'h0001;

    // Timer state; start wins over stop in the same write
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        running[i] <= 1'b0;
        sched[i] <= 1'b0;
        pv[i] <= 14'h0000;
        setv[i] <= 14'h0000;
        period[i] <= 9'h000;
        tenth[i] <= 9'h000;
        decCnt[i] <= 14'h0000;
        subn[i] <= 16'h0000;
        pre[i] <= '0;
      end else if (startHit[i]) begin
        running[i] <= 1'b1;
        sched[i] <= fcB >= itm_pkg::FC_SCHED_BASE;
        pv[i] <= setBin;
        setv[i] <= setBin;
        period[i] <= perUse;
        tenth[i] <= 9'h000;
        decCnt[i] <= 14'h0000;
        subn[i] <= stageSub;
        pre[i] <= '0;
      end else if (stopHit[i]) begin
        running[i] <= 1'b0;
      end else if (running[i]) begin
        pre[i] <= tick[i] ? '0 : pre[i] + PRE_W'(1);
        if (decEv[i]) begin
          tenth[i] <= 9'h000;
          if (expire[i] && sched[i]) begin
            pv[i] <= setv[i];
            decCnt[i] <= 14'h0000;
          end else begin
            pv[i] <= pv[i] - 14'h0001;
            decCnt[i] <= decCnt[i] + 14'h0001;
          end
          if (expire[i] && !sched[i]) begin
            running[i] <= 1'b0;
          end
        end else if (tick[i]) begin
          tenth[i] <= tenth[i] + 9'h001;
        end
      end
    end

    a_oneshot_halt: assert property (@(posedge mclk) disable iff (sys_rst)
      expire[i] && !sched[i] && !startHit[i] |=> !running[i])
      else $error("one-shot timer kept running");
    a_sched_reload: assert property (@(posedge mclk) disable iff (sys_rst)
      expire[i] && sched[i] && !startHit[i] && !stopHit[i]
      |=> running[i] && pv[i] == setv[i])
      else $error("scheduled timer did not reload");
    a_resid_below: assert property (@(posedge mclk) disable iff (sys_rst)
      running[i] |-> tenth[i] < period[i])
      else $error("residual not below period");
    a_dec_step: assert property (@(posedge mclk) disable iff (sys_rst)
      decEv[i] && !expire[i] && !startHit[i] && !stopHit[i]
      |=> pv[i] == $past(pv[i]) - 14'h0001)
      else $error("present value not decremented by one");
    a_stop_halts: assert property (@(posedge mclk) disable iff (sys_rst)
      stopHit[i] |=> !running[i] ##1
      (!running[i] || $past(startHit[i])))
      else $error("stopped timer still running");
    a_req_served: assert property (@(posedge mclk) disable iff (sys_rst)
      expire[i] && !stopHit[i] |-> ##[1:4] subReq && subTimer == 2'(i))
      else $error("expiry request not issued");
  end

  // Lowest pending timer is served first
  always_comb begin
    grant = '0;
    grantIdx = 2'd0;
    for (int k = NT - 1; k >= 0; k--) begin
      if (pending[k]) begin
        grant = NT'(1) << k;
        grantIdx = 2'(k);
      end
    end
  end

  // Pending; expiry outranks the grant clear, a stop in the expiry cycle drops that expiry
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~grant) | (expire & ~stopHit);
    end
  end

  // Subroutine request towards the execution engine
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      subReq <= 1'b0;
      subNum <= 16'h0000;
      subTimer <= 2'd0;
    end else begin
      subReq <= |pending;
      subNum <= pending != '0 ? subn[grantIdx] : 16'h0000;
      subTimer <= grantIdx;
    end
  end

  // Elapsed-time read results; stopped timer reads zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdCnt <= 16'h0000;
      rdPer <= 16'h0000;
      rdRes <= 16'h0000;
    end else if (cmdWr && isRead) begin
      if (running[tIdx]) begin
        rdCnt <= binToBcd(decCnt[tIdx]);
        rdPer <= binToBcd({5'h00, period[tIdx]});
        rdRes <= binToBcd({5'h00, tenth[tIdx]});
      end else begin
        rdCnt <= 16'h0000;
        rdPer <= 16'h0000;
        rdRes <= 16'h0000;
      end
    end
  end

  // Last command outcome, refreshed by every command write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rejected <= 1'b0;
    end else if (cmdWr) begin
      rejected <= !(startOk || isRead || isStop);
    end
  end

  // Read data in the cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        itm_pkg::OFF_SETVAL: regRdata <= {16'h0000, stageSet};
        itm_pkg::OFF_PERIOD: regRdata <= {16'h0000, stagePer};
        itm_pkg::OFF_SUBNUM: regRdata <= {16'h0000, stageSub};
        itm_pkg::OFF_STATUS: regRdata <= {28'h0, rejected, running};
        itm_pkg::OFF_RDCOUNT: regRdata <= {16'h0000, rdCnt};
        itm_pkg::OFF_RDPERIOD: regRdata <= {16'h0000, rdPer};
        itm_pkg::OFF_RDRESID: regRdata <= {16'h0000, rdRes};
        // Command register is write-only; unmapped reads zero
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  a_start_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    startOk |=> running[$past(tIdx)] &&
    sched[$past(tIdx)] == ($past(fcB) >= itm_pkg::FC_SCHED_BASE))
    else $error("start command set wrong mode");
  a_imm_period: assert property (@(posedge mclk) disable iff (sys_rst)
    startOk && immBit |=> period[$past(tIdx)] == itm_pkg::IMM_PERIOD)
    else $error("immediate start without 1 ms period");
  a_reject_keeps: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && isStart && !startOk |=> rejected &&
    running == $past(running & ~(expire & ~sched)))
    else $error("rejected start changed timer state");
  a_tmr2_block: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && isStart && tIdx == 2'd2 &&
    fastCounterSetup != itm_pkg::FAST_SETUP_DEFAULT
    |=> running[2] == $past(running[2] && !(expire[2] && !sched[2])))
    else $error("timer 2 started while fast counter set up");
  a_tmr0_block: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && isStart && tIdx == 2'd0 && pulseSync
    |=> running[0] == $past(running[0] && !(expire[0] && !sched[0])))
    else $error("timer 0 started during pulse output");
  a_read_stopped: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && isRead && !running[tIdx]
    |=> rdCnt == 16'h0000 && rdPer == 16'h0000 && rdRes == 16'h0000)
    else $error("stopped timer read not zero");
  a_read_period: assert property (@(posedge mclk) disable iff (sys_rst)
    cmdWr && isRead && running[tIdx]
    |=> rdPer == binToBcd({5'h00, $past(period[tIdx])}))
    else $error("read period mismatch");
endmodule

// ### itm_pkg.sv
// Constants shared by the interval timer block
// Function
// - Three independent interval timers, numbered 0-2
// - One-shot and repeating scheduled modes
// - Timer 0 barred during pulse output
// - Timer 2 only with fast counter unused
// - Codes 000-002 start one-shot timers
// - Codes 003-005 start scheduled timers
// - Codes 006-008 read elapsed state
// - Immediate set value uses 1 ms period
// - Decrement present value once per period
// - One-shot: request once at zero, halt
// - Scheduled: request, reload, keep running
// - Read returns count, period, residual time
// - Residual time always below the period
// - Reading a stopped timer returns zero
// - Stop halts decrementing and requests
package itm_pkg;
  // Geometry
  localparam int NUM_TIMERS = 3;
  localparam int ADDR_W = 5;
  // Register byte offsets
  localparam logic [4:0] OFF_SETVAL = 5'h00;
  localparam logic [4:0] OFF_PERIOD = 5'h04;
  localparam logic [4:0] OFF_SUBNUM = 5'h08;
  localparam logic [4:0] OFF_CMD = 5'h0C;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_RDCOUNT = 5'h14;
  localparam logic [4:0] OFF_RDPERIOD = 5'h18;
  localparam logic [4:0] OFF_RDRESID = 5'h1C;
  // Command word and status fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_IMM_BIT = 12;
  localparam int CMD_STOP_BIT = 15;
  localparam int STAT_REJ_BIT = 3;
  // Function code bases
  localparam logic [13:0] FC_SCHED_BASE = 14'h0003;
  localparam logic [13:0] FC_READ_BASE = 14'h0006;
  localparam logic [13:0] FC_READ_LAST = 14'h0008;
  // Operand limits
  localparam logic [13:0] PERIOD_MIN = 14'h0005;
  localparam logic [13:0] PERIOD_MAX = 14'h0140;
  localparam logic [8:0] IMM_PERIOD = 9'h00A;
  localparam logic [13:0] SUB_MAX = 14'h00FF;
  // Reset values
  localparam logic [15:0] STAGE_RST = 16'h0000;
  localparam logic [15:0] FAST_SETUP_DEFAULT = 16'h0000;
  // Timing: one period unit is 0.1 ms
  localparam int CLK_PERIOD_NS = 5;
  localparam int UNIT_NS = 100000;
  localparam int UNIT_CYC = UNIT_NS / CLK_PERIOD_NS;
endpackage

// ### itm_sub_engine.sv
// Model of the engine that runs the requested subroutines
`timescale 1ns/100ps
module itm_sub_engine (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic subReq,
  input wire logic [15:0] subNum,
  input wire logic [1:0] subTimer,
  output logic [2:0][7:0] reqCnt,
  output logic [15:0] lastNum
);
  // Count calls per timer; a call is taken the cycle it is offered
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reqCnt <= '0;
      lastNum <= 16'h0000;
    end else if (subReq) begin
      // Index 3 is not a timer, so it is not counted
      if (subTimer != 2'h3) begin
        reqCnt[subTimer] <= reqCnt[subTimer] + 8'h01;
      end
      lastNum <= subNum;
    end
  end
endmodule
